// ==== logic/key_sleep_defs.vh ====
`ifndef KEY_SLEEP_DEFS_VH
`define KEY_SLEEP_DEFS_VH

// ----------------------------------------
// frame bytes
// ----------------------------------------
`define HDR_COMMAND      8'h6b
`define HDR_REPLY        8'h15
`define OPC_REWRITE      8'h07
`define OPC_SLEEP        8'h0d
`define OPC_NONCE        8'h0f
`define RPL_REWRITE      8'h87
`define RPL_SLEEP        8'h8d
`define RPL_NONCE        8'h8f
`define LEN_HIGH         8'h00
`define LEN_REWRITE_LOW  8'h13
`define LEN_SLEEP_LOW    8'h04
`define LEN_NONCE_LOW    8'h03
`define LEN_STATUS_LOW   8'h04
`define LEN_NONCE_RPL    8'h13
`define DLEN_REWRITE     8'h20
`define DLEN_SLEEP       8'h01
`define DLEN_NONCE_REQ   8'h00
`define DLEN_STATUS      8'h01
`define DLEN_NONCE_RPL   8'h10
`define STATUS_OK        8'h00
`define STATUS_FAIL      8'h01

// ----------------------------------------
// sleep settings and timing
// ----------------------------------------
`define SLEEP_SEL_60     8'h00
`define SLEEP_SEL_90     8'h01
`define SLEEP_SEL_120    8'h02
`define SLEEP_SEL_180    8'h03
`define SLEEP_SEL_OFF    8'h04
`define SLEEP_S_60       8'd60
`define SLEEP_S_90       8'd90
`define SLEEP_S_120      8'd120
`define SLEEP_S_180      8'd180
`define CLK_PERIOD_NS    40
`define SECOND_NS        1000000000
`define SECOND_CYCLES    (`SECOND_NS / `CLK_PERIOD_NS)

// ----------------------------------------
// frame geometry
// ----------------------------------------
`define STATUS_DATA_IDX  5'd5
`define STATUS_LAST_IDX  5'd6
`define NONCE_LAST_IDX   5'd21
`define MAX_PAYLOAD      32

`endif

// ==== logic/key_sleep_cmd.v ====
// Overview of operation
// [RULE1] command frames open with 6bh, then a two-byte length, low byte first
// [RULE2] last byte is xor of all other bytes; sent on replies, checked on requests
// [RULE3] opcode 07h with length 1300h is a master key rewrite request
// [RULE4] host sends data length 20h and 32 bytes: encrypted nonce, encrypted new key
// [RULE5] payload decrypted with current key; new key kept only if nonce matches
// [RULE6] rewrite reply: 15h, 0400h, 87h, 01h, status 00h ok or 01h fail
// [RULE7] after reset sleep follows 60 s of continuous idle unless reconfigured
// [RULE8] opcode 0dh with length 0400h and data length 01h sets the sleep interval
// [RULE9] setting 00h 60 s, 01h 90 s, 02h 120 s, 03h 180 s, 04h disables sleep
// [RULE10] accepted setting becomes the idle time before sleep
// [RULE11] sleep reply: 15h, 0400h, 8dh, 01h, status 00h ok or 01h fail
// [RULE12] opcode 0fh returns a fresh 16-byte nonce under 8fh and keeps it
// [RULE13] valid frame restarts idle timer; bad checksum or setting above 04h fails
`timescale 1ns/1ps
`include "key_sleep_defs.vh"

module key_sleep_cmd #(
  parameter [127:0] DEFAULT_KEY   = 128'h0123456789abcdef0123456789abcdef,
  parameter         SECOND_TICKS  = `SECOND_CYCLES
) (
  input  wire         core_clk,
  input  wire         rst_n,
  input  wire         rx_valid,
  output wire         rx_ready,
  input  wire [7:0]   rx_data,
  output wire         tx_valid,
  input  wire         tx_ready,
  output wire [7:0]   tx_data,
  input  wire [127:0] rnd_value,
  output reg          aes_start,
  output reg  [127:0] aes_din,
  output wire [127:0] aes_key,
  input  wire         aes_done,
  input  wire [127:0] aes_dout,
  output reg  [127:0] master_key,
  output reg          key_updated,
  output reg          sleep_active,
  output reg  [7:0]   sleep_setting
);

  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam [10:0] S_HDR  = 11'h001;
  localparam [10:0] S_LENL = 11'h002;
  localparam [10:0] S_LENH = 11'h004;
  localparam [10:0] S_OPC  = 11'h008;
  localparam [10:0] S_PLEN = 11'h010;
  localparam [10:0] S_DATA = 11'h020;
  localparam [10:0] S_FRAME_XOR_CHECK = 11'h040;
  localparam [10:0] S_EXEC = 11'h080;
  localparam [10:0] S_AES1 = 11'h100;
  localparam [10:0] S_AES2 = 11'h200;
  localparam [10:0] S_TX   = 11'h400;

  reg  [10:0] state_reg;
  reg  [7:0]  len_lo_reg;
  reg  [7:0]  len_hi_reg;
  reg  [7:0]  opc_reg;
  reg  [7:0]  plen_reg;
  reg  [7:0]  cnt_reg;
  reg  [7:0]  xor_reg;
  reg         frame_xor_check_ok_reg;
  reg  [7:0]  payload [0:`MAX_PAYLOAD-1];
  reg  [127:0] nonce_reg;
  reg         nonce_valid_reg;
  reg  [7:0]  rpl_code_reg;
  reg  [7:0]  rpl_status_reg;
  reg         rpl_nonce_reg;
  reg  [4:0]  tx_idx_reg;
  reg  [7:0]  tx_xor_reg;
  reg         frame_ok;
  reg  [7:0]  tx_byte;
  reg  [4:0]  tx_last;
  wire        push_ready;
  wire        push;
  wire [7:0]  rx_byte;
  wire        rx_take;
  wire        req_ok;
  wire [127:0] block_a;
  wire [127:0] block_b;

  assign rx_ready = (state_reg == S_HDR) | (state_reg == S_LENL) | (state_reg == S_LENH) |
                    (state_reg == S_OPC) | (state_reg == S_PLEN) | (state_reg == S_DATA) |
                    (state_reg == S_FRAME_XOR_CHECK);
  assign rx_take  = rx_valid & rx_ready;
  assign rx_byte  = rx_data;
  assign aes_key  = master_key;

  genvar g;
  generate
    for (g = 0; g < 16; g = g + 1) begin : g_blk
      assign block_a[127-8*g -: 8] = payload[g];
      assign block_b[127-8*g -: 8] = payload[g+16];
    end
  endgenerate

  // ----------------------------------------
  // request validity per opcode
  // ----------------------------------------
  assign req_ok = frame_xor_check_ok_reg & (len_hi_reg == `LEN_HIGH) & (
    ((opc_reg == `OPC_REWRITE) & (len_lo_reg == `LEN_REWRITE_LOW) &
     (plen_reg == `DLEN_REWRITE)) |                                        // see [RULE3] [RULE4]
    ((opc_reg == `OPC_SLEEP) & (len_lo_reg == `LEN_SLEEP_LOW) &
     (plen_reg == `DLEN_SLEEP)) |                                          // see [RULE8]
    ((opc_reg == `OPC_NONCE) & (len_lo_reg == `LEN_NONCE_LOW) &
     (plen_reg == `DLEN_NONCE_REQ)));

  // ----------------------------------------
  // reply byte generator
  // ----------------------------------------
  always @* begin
    tx_last = rpl_nonce_reg ? `NONCE_LAST_IDX : `STATUS_LAST_IDX;
    case (tx_idx_reg)
      5'd0:    tx_byte = `HDR_REPLY;
      5'd1:    tx_byte = rpl_nonce_reg ? `LEN_NONCE_RPL : `LEN_STATUS_LOW; // see [RULE6] [RULE11]
      5'd2:    tx_byte = `LEN_HIGH;
      5'd3:    tx_byte = rpl_code_reg;
      5'd4:    tx_byte = rpl_nonce_reg ? `DLEN_NONCE_RPL : `DLEN_STATUS;
      default: tx_byte = rpl_nonce_reg ? nonce_reg[127 - 8*(tx_idx_reg - 5'd5) -: 8]
                                       : rpl_status_reg;
    endcase
    if (tx_idx_reg == tx_last)
      tx_byte = tx_xor_reg;                                                 // see [RULE2]
  end

  assign push = (state_reg == S_TX) & push_ready;

  // ----------------------------------------
  // frame engine
  // ----------------------------------------
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg       <= S_HDR;
      len_lo_reg      <= 8'h00;
      len_hi_reg      <= 8'h00;
      opc_reg         <= 8'h00;
      plen_reg        <= 8'h00;
      cnt_reg         <= 8'h00;
      xor_reg         <= 8'h00;
      frame_xor_check_ok_reg     <= 1'b0;
      nonce_reg       <= 128'h0;
      nonce_valid_reg <= 1'b0;
      rpl_code_reg    <= 8'h00;
      rpl_status_reg  <= 8'h00;
      rpl_nonce_reg   <= 1'b0;
      tx_idx_reg      <= 5'd0;
      tx_xor_reg      <= 8'h00;
      aes_start       <= 1'b0;
      aes_din         <= 128'h0;
      master_key      <= DEFAULT_KEY;
      key_updated     <= 1'b0;
      sleep_setting   <= `SLEEP_SEL_60;
      frame_ok        <= 1'b0;
    end else begin
      aes_start   <= 1'b0;
      key_updated <= 1'b0;
      frame_ok    <= 1'b0;
      case (state_reg)
        S_HDR: if (rx_take && rx_byte == `HDR_COMMAND) begin               // see [RULE1]
          xor_reg   <= rx_byte;
          state_reg <= S_LENL;
        end
        S_LENL: if (rx_take) begin
          len_lo_reg <= rx_byte;                                            // see [RULE1]
          xor_reg    <= xor_reg ^ rx_byte;
          state_reg  <= S_LENH;
        end
        S_LENH: if (rx_take) begin
          len_hi_reg <= rx_byte;
          xor_reg    <= xor_reg ^ rx_byte;
          state_reg  <= S_OPC;
        end
        S_OPC: if (rx_take) begin
          opc_reg   <= rx_byte;
          xor_reg   <= xor_reg ^ rx_byte;
          state_reg <= S_PLEN;
        end
        S_PLEN: if (rx_take) begin
          plen_reg  <= rx_byte;
          xor_reg   <= xor_reg ^ rx_byte;
          cnt_reg   <= 8'h00;
          state_reg <= (rx_byte == 8'h00) ? S_FRAME_XOR_CHECK : S_DATA;
        end
        S_DATA: if (rx_take) begin
          // bytes past the buffer are still summed but not kept
          if (cnt_reg < `MAX_PAYLOAD)
            payload[cnt_reg[4:0]] <= rx_byte;
          xor_reg <= xor_reg ^ rx_byte;
          cnt_reg <= cnt_reg + 8'h01;
          if (cnt_reg + 8'h01 == plen_reg)
            state_reg <= S_FRAME_XOR_CHECK;
        end
        S_FRAME_XOR_CHECK: if (rx_take) begin
          frame_xor_check_ok_reg <= ((xor_reg ^ rx_byte) == 8'h00);                   // see [RULE2]
          state_reg   <= S_EXEC;
        end
        S_EXEC: begin
          frame_ok       <= frame_xor_check_ok_reg;                                    // see [RULE13]
          tx_idx_reg     <= 5'd0;
          tx_xor_reg     <= 8'h00;
          rpl_nonce_reg  <= 1'b0;
          rpl_status_reg <= `STATUS_FAIL;                                   // see [RULE13]
          state_reg      <= S_TX;
          case (opc_reg)
            `OPC_NONCE: begin
              if (req_ok) begin
                nonce_reg       <= rnd_value;                               // see [RULE12]
                nonce_valid_reg <= 1'b1;
                rpl_code_reg    <= `RPL_NONCE;
                rpl_nonce_reg   <= 1'b1;
              end else
                state_reg <= S_HDR;
            end
            `OPC_REWRITE: begin
              rpl_code_reg <= `RPL_REWRITE;
              if (req_ok && nonce_valid_reg) begin
                aes_din   <= block_a;                                       // see [RULE5]
                aes_start <= 1'b1;
                state_reg <= S_AES1;
              end
            end
            `OPC_SLEEP: begin
              rpl_code_reg <= `RPL_SLEEP;
              if (req_ok && payload[0] <= `SLEEP_SEL_OFF) begin             // see [RULE13]
                sleep_setting  <= payload[0];                               // see [RULE10]
                rpl_status_reg <= `STATUS_OK;
              end
            end
            default: state_reg <= S_HDR;
          endcase
        end
        S_AES1: if (aes_done) begin
          if (aes_dout == nonce_reg) begin                                  // see [RULE5]
            aes_din   <= block_b;
            aes_start <= 1'b1;
            state_reg <= S_AES2;
          end else begin
            nonce_valid_reg <= 1'b0;
            state_reg       <= S_TX;
          end
        end
        S_AES2: if (aes_done) begin
          // the nonce is single use so a replayed payload cannot rekey twice
          master_key      <= aes_dout;                                      // see [RULE5]
          key_updated     <= 1'b1;
          nonce_valid_reg <= 1'b0;
          rpl_status_reg  <= `STATUS_OK;                                    // see [RULE6]
          state_reg       <= S_TX;
        end
        S_TX: if (push) begin
          tx_xor_reg <= tx_xor_reg ^ tx_byte;
          tx_idx_reg <= tx_idx_reg + 5'd1;
          if (tx_idx_reg == tx_last)
            state_reg <= S_HDR;
        end
        default: state_reg <= S_HDR;
      endcase
    end
  end

  // ----------------------------------------
  // two-entry reply buffer
  // ----------------------------------------
  reg  [7:0] buf0_reg;
  reg  [7:0] buf1_reg;
  reg  [1:0] fill_reg;
  wire       pop;

  assign tx_valid   = (fill_reg != 2'd0);
  assign tx_data    = buf0_reg;
  assign push_ready = (fill_reg != 2'd2);
  assign pop        = tx_valid & tx_ready;

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      buf0_reg <= 8'h00;
      buf1_reg <= 8'h00;
      fill_reg <= 2'd0;
    end else begin
      case ({push, pop})
        2'b10: begin
          if (fill_reg == 2'd0)
            buf0_reg <= tx_byte;
          else
            buf1_reg <= tx_byte;
          fill_reg <= fill_reg + 2'd1;
        end
        2'b01: begin
          buf0_reg <= buf1_reg;
          fill_reg <= fill_reg - 2'd1;
        end
        2'b11: begin
          if (fill_reg == 2'd1)
            buf0_reg <= tx_byte;
          else begin
            buf0_reg <= buf1_reg;
            buf1_reg <= tx_byte;
          end
        end
        default: fill_reg <= fill_reg;
      endcase
    end
  end

  // ----------------------------------------
  // idle timer
  // ----------------------------------------
  reg  [31:0] tick_cnt_reg;
  reg  [7:0]  idle_sec_reg;
  reg  [7:0]  limit;
  wire        sec_tick;

  assign sec_tick = (tick_cnt_reg == SECOND_TICKS - 1);

  always @* begin
    case (sleep_setting)                                                    // see [RULE9]
      `SLEEP_SEL_90:  limit = `SLEEP_S_90;
      `SLEEP_SEL_120: limit = `SLEEP_S_120;
      `SLEEP_SEL_180: limit = `SLEEP_S_180;
      default:        limit = `SLEEP_S_60;
    endcase
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_reg <= 32'd0;
      idle_sec_reg <= 8'd0;
      sleep_active <= 1'b0;
    end else if (frame_ok) begin
      // any good frame wakes the reader and restarts the idle span
      tick_cnt_reg <= 32'd0;                                                // see [RULE13]
      idle_sec_reg <= 8'd0;
      sleep_active <= 1'b0;
    end else if (sleep_setting == `SLEEP_SEL_OFF) begin
      tick_cnt_reg <= 32'd0;                                                // see [RULE9]
      idle_sec_reg <= 8'd0;
      sleep_active <= 1'b0;
    end else begin
      tick_cnt_reg <= sec_tick ? 32'd0 : tick_cnt_reg + 32'd1;
      if (sec_tick && idle_sec_reg < limit)
        idle_sec_reg <= idle_sec_reg + 8'd1;
      if (idle_sec_reg >= limit)
        sleep_active <= 1'b1;                                               // see [RULE7] [RULE10]
    end
  end

endmodule // key_sleep_cmd

// ==== sim/key_sleep_checker.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// port relations of the command handler
// ----------------------------------------
module key_sleep_checker (
  input wire         core_clk,
  input wire         rst_n,
  input wire         rx_ready,
  input wire         tx_valid,
  input wire         tx_ready,
  input wire [7:0]   tx_data,
  input wire         aes_start,
  input wire [127:0] aes_din,
  input wire [127:0] aes_key,
  input wire [127:0] master_key,
  input wire         key_updated,
  input wire         sleep_active,
  input wire [7:0]   sleep_setting
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_tx_stall; tx_valid && !tx_ready; endsequence
  sequence s_off_held; (sleep_setting == 8'h04) [*2]; endsequence
  property p_tx_hold; s_tx_stall |=> tx_valid && $stable(tx_data); endproperty
  property p_off_awake; s_off_held |-> !sleep_active; endproperty
  property p_key_pulse; key_updated |=> !key_updated; endproperty
  property p_key_cause; $changed(master_key) |-> key_updated || $past(key_updated); endproperty
  property p_key_busy; $changed(master_key) |-> !rx_ready; endproperty
  property p_aes_pulse; aes_start |=> !aes_start; endproperty
  property p_aes_busy; aes_start |-> !rx_ready && !key_updated; endproperty
  property p_set_range; sleep_setting <= 8'h04; endproperty
  property p_set_busy; $changed(sleep_setting) |-> !rx_ready; endproperty
  property p_sleep_idle; $rose(sleep_active) |-> rx_ready; endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("reply byte lost in stall");
  a_off_awake: assert property (p_off_awake) else $error("asleep while disabled");
  a_key_pulse: assert property (p_key_pulse) else $error("key pulse too long");
  a_key_cause: assert property (p_key_cause) else $error("key moved silently");
  a_key_busy: assert property (p_key_busy) else $error("key moved while idle");
  a_aes_pulse: assert property (p_aes_pulse) else $error("aes start too long");
  a_aes_busy: assert property (p_aes_busy) else $error("aes start mid frame");
  a_set_range: assert property (p_set_range) else $error("setting out of range");
  a_set_busy: assert property (p_set_busy) else $error("setting moved while idle");
  a_sleep_idle: assert property (p_sleep_idle) else $error("slept mid frame");
endmodule // key_sleep_checker

bind key_sleep_cmd key_sleep_checker chk_inst (.core_clk(core_clk), .rst_n(rst_n),
  .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
  .aes_start(aes_start), .aes_din(aes_din), .aes_key(aes_key), .master_key(master_key),
  .key_updated(key_updated), .sleep_active(sleep_active), .sleep_setting(sleep_setting));

// ==== sim/host_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// host: sends queued bytes, drains replies with stalls
// ----------------------------------------
module host_model (
  input  wire       core_clk,
  input  wire       rst_n,
  output reg        rx_valid,
  input  wire       rx_ready,
  output reg  [7:0] rx_data,
  input  wire       tx_valid,
  output reg        tx_ready,
  input  wire [7:0] tx_data
);
  logic [7:0] out_q[$];
  logic [7:0] in_q[$];
  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    tx_ready = 1'b0;
    forever begin
      @(posedge core_clk);
      if (rx_valid && rx_ready === 1'b1)
        void'(out_q.pop_front());
      if (tx_ready && tx_valid === 1'b1)
        in_q.push_back(tx_data);
      #1;
      rx_valid = rst_n && out_q.size() != 0;
      // released data line shows the inverse so a stale byte never looks valid
      rx_data  = rx_valid ? out_q[0] : ~rx_data;
      tx_ready = rst_n && $urandom_range(0, 3) != 0;
    end
  end
endmodule // host_model

// ==== sim/key_sleep_cmd_tb.sv ====
`timescale 1ns/1ps
`include "key_sleep_defs.vh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("ERROR %0t mismatch got %h exp %h", $time, g, e); end end
module key_sleep_cmd_tb;
  localparam [127:0] KEY0 = 128'h00112233445566778899aabbccddeeff; // arbitrary
  localparam         TICKS = 4;
  reg         core_clk, rst_n, aes_done;
  reg [127:0] aes_dout, rnd_value, blk, exp_key, nk, aes_blk;
  wire        rx_valid, rx_ready, tx_valid, tx_ready, aes_start, key_updated, sleep_active;
  wire [7:0]  rx_data, tx_data, sleep_setting;
  wire [127:0] aes_din, aes_key, master_key;
  int         n_fail, total_checks, secs;
  logic [7:0] q[$];
  logic [7:0] exp_set;

  key_sleep_cmd #(.DEFAULT_KEY(KEY0), .SECOND_TICKS(TICKS)) key_sleep_cmd_inst (
    .core_clk(core_clk), .rst_n(rst_n), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .rx_data(rx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .rnd_value(rnd_value), .aes_start(aes_start), .aes_din(aes_din), .aes_key(aes_key),
    .aes_done(aes_done), .aes_dout(aes_dout), .master_key(master_key),
    .key_updated(key_updated), .sleep_active(sleep_active), .sleep_setting(sleep_setting));
  host_model host_model_inst (.core_clk(core_clk), .rst_n(rst_n), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_data(rx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_data(tx_data));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // ----------------------------------------
  // stand-in cipher: xor with key, slow by a random few cycles
  // ----------------------------------------
  initial begin
    aes_done = 1'b0;
    aes_dout = 128'h0;
    forever begin
      @(posedge core_clk);
      if (aes_start === 1'b1) begin
        aes_blk = aes_din ^ aes_key;
        repeat ($urandom_range(1, 4)) @(posedge core_clk);
        #1 aes_done = 1'b1;
        aes_dout = aes_blk;
        @(posedge core_clk);
        #1 aes_done = 1'b0;
        aes_dout = ~aes_blk;
      end
    end
  end

  task automatic frame(input logic [7:0] b[$], input logic [7:0] bad);
    logic [7:0] x;
    x = bad;
    foreach (b[i]) x ^= b[i];
    b.push_back(x);
    foreach (b[i]) host_model_inst.out_q.push_back(b[i]);
  endtask

  task automatic expect_reply(input logic [7:0] r[$]);
    logic [7:0] x;
    int n;
    x = 8'h00;
    n = 0;
    foreach (r[i]) x ^= r[i];
    r.push_back(x);
    while (host_model_inst.in_q.size() < r.size() && n < 3000) begin
      @(posedge core_clk);
      n++;
    end
    repeat (4) @(posedge core_clk);
    #1;
    `CHK(host_model_inst.in_q.size(), r.size())
    foreach (r[i]) `CHK(host_model_inst.in_q[i], r[i])
    host_model_inst.in_q.delete();
  endtask

  task stop_test;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    #(40 * 30000);
    n_fail++;
    stop_test;
  end

  initial begin
    n_fail = 0;
    total_checks = 0;
    rst_n = 1'b0;
    rnd_value = 128'h0;
    exp_key = KEY0;
    exp_set = 8'h00;
    void'($urandom(16));
    repeat (20) @(posedge core_clk);
    #1 rst_n = 1'b1;
    `CHK(sleep_setting, 8'h00)
    // setting codes, one out of range, then a corrupted checksum
    for (int s = 0; s < 7; s++) begin
      frame({8'h6b, 8'h04, 8'h00, 8'h0d, 8'h01, s[7:0] % 8'h06}, s == 6);
      expect_reply({8'h15, 8'h04, 8'h00, 8'h8d, 8'h01, (s < 5) ? 8'h00 : 8'h01});
      if (s < 5) exp_set = s[7:0];
      `CHK(sleep_setting, exp_set)
    end
    $display("test settings done");
    // idle timer at every interval, then disabled
    for (int s = 0; s < 5; s++) begin
      secs = (s == 4) ? 200 : (s == 3) ? 180 : 60 + 30 * s;
      frame({8'h6b, 8'h04, 8'h00, 8'h0d, 8'h01, s[7:0]}, 0);
      expect_reply({8'h15, 8'h04, 8'h00, 8'h8d, 8'h01, 8'h00});
      `CHK(sleep_active, 1'b0)
      repeat ((secs - 8) * TICKS) @(posedge core_clk);
      #1 `CHK(sleep_active, 1'b0)
      repeat (16 * TICKS) @(posedge core_clk);
      #1 `CHK(sleep_active, s != 4)
    end
    $display("test idle done");
    // nonce and good rewrite, rewrite with no nonce held, then a wrong nonce
    for (int t = 0; t < 3; t++) begin
      rnd_value = {$urandom, $urandom, $urandom, $urandom};
      nk = {$urandom, $urandom, $urandom, $urandom};
      if (t != 1) begin
        frame({8'h6b, 8'h03, 8'h00, 8'h0f, 8'h00}, 0);
        q = {8'h15, 8'h13, 8'h00, 8'h8f, 8'h10};
        for (int i = 0; i < 16; i++) q.push_back(rnd_value[127 - 8 * i -: 8]);
        expect_reply(q);
      end
      q = {8'h6b, 8'h13, 8'h00, 8'h07, 8'h20};
      // the last pass flips one bit of the encrypted nonce
      blk = rnd_value ^ exp_key ^ {127'h0, t == 2};
      for (int i = 0; i < 16; i++) q.push_back(blk[127 - 8 * i -: 8]);
      blk = nk ^ exp_key;
      for (int i = 0; i < 16; i++) q.push_back(blk[127 - 8 * i -: 8]);
      frame(q, 0);
      expect_reply({8'h15, 8'h04, 8'h00, 8'h87, 8'h01, (t == 0) ? 8'h00 : 8'h01});
      if (t == 0) exp_key = nk;
      `CHK(master_key, exp_key)
    end
    $display("test rewrite done");
    // a second reset restores the key and the default idle span
    rst_n = 1'b0;
    repeat (2) @(posedge core_clk);
    #1 rst_n = 1'b1;
    `CHK(master_key, KEY0)
    `CHK(sleep_setting, 8'h00)
    repeat (52 * TICKS) @(posedge core_clk);
    #1 `CHK(sleep_active, 1'b0)
    repeat (16 * TICKS) @(posedge core_clk);
    #1 `CHK(sleep_active, 1'b1)
    $display("test reset done");
    stop_test;
  end
endmodule // key_sleep_cmd_tb
